// file: logic/reset_cause_cfg.svh
// offsets, field positions, reset values and masks of the reset-cause block
`ifndef RESET_CAUSE_CFG_SVH
`define RESET_CAUSE_CFG_SVH

`define STATUS_OFS       8'h00
`define IRQ_STAT_OFS     8'h04
`define IRQ_CLR_OFS      8'h08
`define IRQ_EN_OFS       8'h0C

`define BIT_CFG_MISMATCH 9
`define BIT_REG_STANDBY  8
`define BIT_EXT_PIN      7
`define BIT_SOFTWARE     6
`define BIT_WATCHDOG     4
`define BIT_WAKE_SLEEP   3
`define BIT_WAKE_IDLE    2
`define BIT_BROWNOUT     1
`define BIT_POWER_ON     0

`define FLAG_MASK        32'h0000_02DF
`define WRITE_MASK       32'h0000_03DF
`define STATUS_RESET     32'h0000_0003

`endif

// file: logic/reset_cause_pkg.sv
// types shared by the reset-cause block
package reset_cause_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DATA
    } bus_state_type;

    typedef logic [31:0] word_type;

endpackage : reset_cause_pkg

// file: logic/ahb_word_port.sv
// AHB-Lite slave front end: word writes with no wait, reads with one wait state
`timescale 1ns/100ps

module ahb_word_port (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      hsel,
    input  wire logic [7:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire reset_cause_pkg::word_type hwdata,
    output logic                           hreadyout,
    output logic                           hresp,
    output reset_cause_pkg::word_type      hrdata,
    output logic                           wr_en,
    output logic [7:0]                     reg_addr,
    output reset_cause_pkg::word_type      wr_data,
    input  wire reset_cause_pkg::word_type rd_data
);

    reset_cause_pkg::bus_state_type state_r;
    reset_cause_pkg::bus_state_type state_nxt;
    logic [7:0]                     addr_r;
    reset_cause_pkg::word_type      hrdata_r;
    wire                            accept;
    wire                            word_size;

    assign word_size = (hsize == 3'h2);
    assign accept    = hsel && htrans[1] && hready && word_size;
    assign hreadyout = (state_r != reset_cause_pkg::BUS_READ_WAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign wr_en     = (state_r == reset_cause_pkg::BUS_WRITE);
    assign reg_addr  = addr_r;
    assign wr_data   = hwdata;

    always_comb begin
        case (state_r)
            reset_cause_pkg::BUS_READ_WAIT: state_nxt = reset_cause_pkg::BUS_READ_DATA;
            default: begin
                if (!accept)
                    state_nxt = reset_cause_pkg::BUS_IDLE;
                else if (hwrite)
                    state_nxt = reset_cause_pkg::BUS_WRITE;
                else
                    state_nxt = reset_cause_pkg::BUS_READ_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r  <= reset_cause_pkg::BUS_IDLE;
            addr_r   <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            if (accept && state_r != reset_cause_pkg::BUS_READ_WAIT)
                addr_r <= {haddr[7:2], 2'h0};
            if (state_r == reset_cause_pkg::BUS_READ_WAIT)
                hrdata_r <= rd_data;
        end
    end

endmodule : ahb_word_port

// file: logic/reset_cause_flags.sv
// reset-cause flag register with regulator standby control and event interrupt
`timescale 1ns/100ps
`include "reset_cause_cfg.svh"

module reset_cause_flags (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      hsel,
    input  wire logic [7:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire reset_cause_pkg::word_type hwdata,
    output logic                           hreadyout,
    output logic                           hresp,
    output reset_cause_pkg::word_type      hrdata,
    input  wire logic                      config_mismatch_reset,
    input  wire logic                      master_clear_pin_reset,
    input  wire logic                      software_reset,
    input  wire logic                      watchdog_timer_expired,
    input  wire logic                      brownout_reset,
    input  wire logic                      power_on_reset,
    input  wire logic                      sleep_mode,
    input  wire logic                      idle_mode,
    output logic                           regulator_enable,
    output logic                           irq
);

    reset_cause_pkg::word_type status_r;
    reset_cause_pkg::word_type status_nxt;
    reset_cause_pkg::word_type irq_stat_r;
    reset_cause_pkg::word_type irq_stat_nxt;
    reset_cause_pkg::word_type irq_en_r;
    reset_cause_pkg::word_type irq_en_nxt;
    reset_cause_pkg::word_type events;
    reset_cause_pkg::word_type rd_data;
    reset_cause_pkg::word_type wr_data;
    logic                      sleep_prev_r;
    logic                      idle_prev_r;
    logic                      regulator_enable_r;
    logic                      wr_en;
    logic [7:0]                reg_addr;
    wire                       wake_sleep;
    wire                       wake_idle;
    wire                       status_wr;
    wire                       irq_clr_wr;
    wire                       irq_en_wr;
    wire                       bus_start;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    ahb_word_port i_ahb_word_port (
        .clk       (clk),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_en     (wr_en),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data),
        .rd_data   (rd_data)
    );

    // leaving a low-power mode is the falling edge of its level
    assign wake_sleep = sleep_prev_r && !sleep_mode;
    assign wake_idle  = idle_prev_r && !idle_mode;

    // event vector in the flag layout
    always_comb begin
        events                      = 32'h0000_0000;
        events[`BIT_CFG_MISMATCH]   = config_mismatch_reset;
        events[`BIT_EXT_PIN]        = master_clear_pin_reset;
        events[`BIT_SOFTWARE]       = software_reset;
        events[`BIT_WATCHDOG]       = watchdog_timer_expired;
        events[`BIT_WAKE_SLEEP]     = wake_sleep;
        events[`BIT_WAKE_IDLE]      = wake_idle;
        events[`BIT_BROWNOUT]       = brownout_reset;
        events[`BIT_POWER_ON]       = power_on_reset;
    end

    assign status_wr  = wr_en && hit(reg_addr, `STATUS_OFS);
    assign irq_clr_wr = wr_en && hit(reg_addr, `IRQ_CLR_OFS);
    assign irq_en_wr  = wr_en && hit(reg_addr, `IRQ_EN_OFS);

    // word transfer taken at this edge, for the bus checks
    assign bus_start  = hsel && htrans[1] && hready && hreadyout && (hsize == 3'h2);

    // hardware set wins over a software write of zero
    assign status_nxt = ((status_wr ? (wr_data & `WRITE_MASK) : status_r) | events) & `WRITE_MASK;
    assign irq_stat_nxt = ((irq_clr_wr ? (irq_stat_r & ~wr_data) : irq_stat_r) | events) & `FLAG_MASK;
    assign irq_en_nxt   = irq_en_wr ? (wr_data & `FLAG_MASK) : irq_en_r;

    // unmapped offsets and the clear register read zero
    assign rd_data = hit(reg_addr, `STATUS_OFS)   ? status_r   :
                     hit(reg_addr, `IRQ_STAT_OFS) ? irq_stat_r :
                     hit(reg_addr, `IRQ_EN_OFS)   ? irq_en_r   : 32'h0000_0000;

    assign irq              = |(irq_stat_r & irq_en_r);
    assign regulator_enable = regulator_enable_r;

    // nrst is the power-on reset; other resets arrive as events and clear nothing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= `STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= 32'h0000_0000;
            irq_en_r   <= 32'h0000_0000;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r   <= irq_en_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sleep_prev_r       <= 1'b0;
            idle_prev_r        <= 1'b0;
            regulator_enable_r <= 1'b1;
        end else begin
            sleep_prev_r       <= sleep_mode;
            idle_prev_r        <= idle_mode;
            regulator_enable_r <= !sleep_mode || status_r[`BIT_REG_STANDBY];
        end
    end

    a_cfg_mismatch_set: assert property (@(posedge clk) disable iff (!nrst)
        config_mismatch_reset |=> status_r[9])
        else $error("mismatch flag not set after its event");

    a_regulator_standby: assert property (@(posedge clk) disable iff (!nrst)
        sleep_mode && !status_r[8] && !status_wr |=> !regulator_enable ##1 (sleep_mode || regulator_enable))
        else $error("regulator state does not follow standby bit");

    a_regulator_kept_on: assert property (@(posedge clk) disable iff (!nrst)
        status_r[8] && !status_wr |=> regulator_enable)
        else $error("regulator turned off while standby bit set");

    a_ext_pin_set: assert property (@(posedge clk) disable iff (!nrst)
        master_clear_pin_reset |=> status_r[7] && irq_stat_r[7])
        else $error("pin reset flag not set");

    a_software_set: assert property (@(posedge clk) disable iff (!nrst)
        software_reset |=> status_r[6])
        else $error("software reset flag not set");

    a_watchdog_set: assert property (@(posedge clk) disable iff (!nrst)
        watchdog_timer_expired |=> status_r[4])
        else $error("watchdog flag not set");

    a_wake_sleep_set: assert property (@(posedge clk) disable iff (!nrst)
        sleep_mode ##1 !sleep_mode |=> status_r[3])
        else $error("wake from sleep flag not set");

    a_wake_idle_set: assert property (@(posedge clk) disable iff (!nrst)
        idle_mode ##1 !idle_mode |=> status_r[2])
        else $error("wake from idle flag not set");

    a_brownout_set: assert property (@(posedge clk) disable iff (!nrst)
        brownout_reset |=> status_r[1])
        else $error("brown-out flag not set");

    a_power_on_set: assert property (@(posedge clk) disable iff (!nrst)
        power_on_reset |=> status_r[0])
        else $error("power-on flag not set");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        hit(reg_addr, `STATUS_OFS) && !hreadyout |=> (hrdata[31:10] == 22'h0) && !hrdata[5])
        else $error("reserved status bits read nonzero");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr |=> (($past(status_r) & ~status_r) == 32'h0000_0000))
        else $error("flag cleared without a software write");

    a_software_clear: assert property (@(posedge clk) disable iff (!nrst)
        status_wr && (events == 32'h0000_0000) |=> status_r == (($past(wr_data)) & 32'h0000_03DF))
        else $error("status write not stored");

    a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
        software_reset && irq_en_r[6] && !irq_en_wr |=> irq)
        else $error("enabled event did not raise interrupt");

    a_cfg_mismatch_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !config_mismatch_reset && !status_r[9] |=> !status_r[9])
        else $error("mismatch flag set with no event");

    a_ext_pin_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !master_clear_pin_reset && !status_r[7] |=> !status_r[7])
        else $error("pin reset flag set with no event");

    a_software_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !software_reset && !status_r[6] |=> !status_r[6])
        else $error("software reset flag set with no event");

    a_watchdog_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !watchdog_timer_expired && !status_r[4] |=> !status_r[4])
        else $error("watchdog flag set with no event");

    a_wake_sleep_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !wake_sleep && !status_r[3] |=> !status_r[3])
        else $error("wake from sleep flag set with no wake");

    a_wake_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !wake_idle && !status_r[2] |=> !status_r[2])
        else $error("wake from idle flag set with no wake");

    a_brownout_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !brownout_reset && !status_r[1] |=> !status_r[1])
        else $error("brown-out flag set with no event");

    a_power_on_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr && !power_on_reset && !status_r[0] |=> !status_r[0])
        else $error("power-on flag set with no event");

    a_standby_hold: assert property (@(posedge clk) disable iff (!nrst)
        !status_wr |=> $stable(status_r[8]))
        else $error("standby bit changed without a write");

    a_standby_write: assert property (@(posedge clk) disable iff (!nrst)
        status_wr |=> status_r[8] == $past(wr_data[8]))
        else $error("standby bit write not stored");

    a_regulator_awake: assert property (@(posedge clk) disable iff (!nrst)
        !sleep_mode |=> regulator_enable)
        else $error("regulator off while awake");

    a_status_reserved: assert property (@(posedge clk) disable iff (!nrst)
        (status_r[31:10] == 22'h0) && !status_r[5])
        else $error("reserved status bits hold ones");

    a_irq_stat_reserved: assert property (@(posedge clk) disable iff (!nrst)
        (irq_stat_r & ~`FLAG_MASK) == 32'h0000_0000)
        else $error("irq status outside flag layout");

    a_irq_en_reserved: assert property (@(posedge clk) disable iff (!nrst)
        (irq_en_r & ~`FLAG_MASK) == 32'h0000_0000)
        else $error("irq enable outside flag layout");

    a_status_write: assert property (@(posedge clk) disable iff (!nrst)
        status_wr |=> ((status_r ^ ($past(wr_data) & `WRITE_MASK)) & ~$past(events)) == 32'h0000_0000)
        else $error("status write not stored in writable bits");

    a_event_over_write: assert property (@(posedge clk) disable iff (!nrst)
        status_wr |=> ($past(events) & ~status_r) == 32'h0000_0000)
        else $error("write in the event cycle dropped a flag");

    a_event_any: assert property (@(posedge clk) disable iff (!nrst)
        events != 32'h0000_0000 |=> ($past(events) & ~status_r) == 32'h0000_0000)
        else $error("event did not set its flag");

    a_irq_sets: assert property (@(posedge clk) disable iff (!nrst)
        events != 32'h0000_0000 |=> ($past(events) & ~irq_stat_r) == 32'h0000_0000)
        else $error("event did not set irq status");

    a_irq_clear: assert property (@(posedge clk) disable iff (!nrst)
        irq_clr_wr |=> (irq_stat_r & $past(wr_data) & ~$past(events)) == 32'h0000_0000)
        else $error("irq clear write left bits set");

    a_irq_sticky: assert property (@(posedge clk) disable iff (!nrst)
        !irq_clr_wr |=> ($past(irq_stat_r) & ~irq_stat_r) == 32'h0000_0000)
        else $error("irq status cleared without a clear write");

    a_irq_no_spurious: assert property (@(posedge clk) disable iff (!nrst)
        events == 32'h0000_0000 |=> (irq_stat_r & ~$past(irq_stat_r)) == 32'h0000_0000)
        else $error("irq status set with no event");

    a_irq_en_write: assert property (@(posedge clk) disable iff (!nrst)
        irq_en_wr |=> irq_en_r == ($past(wr_data) & `FLAG_MASK))
        else $error("irq enable write not stored");

    a_irq_en_hold: assert property (@(posedge clk) disable iff (!nrst)
        !irq_en_wr |=> $stable(irq_en_r))
        else $error("irq enable changed without a write");

    a_irq_quiet: assert property (@(posedge clk) disable iff (!nrst)
        irq_en_r == 32'h0000_0000 |-> !irq)
        else $error("interrupt raised with nothing enabled");

    a_irq_follows: assert property (@(posedge clk) disable iff (!nrst)
        irq_stat_r[4] && irq_en_r[4] |-> irq)
        else $error("enabled watchdog status gives no interrupt");

    a_hresp_okay: assert property (@(posedge clk) disable iff (!nrst)
        !hresp)
        else $error("bus response not okay");

    a_read_wait: assert property (@(posedge clk) disable iff (!nrst)
        bus_start && !hwrite |=> !hreadyout)
        else $error("read data phase without its wait state");

    a_write_no_wait: assert property (@(posedge clk) disable iff (!nrst)
        bus_start && hwrite |=> hreadyout && wr_en)
        else $error("write data phase not taken at once");

    a_wait_single: assert property (@(posedge clk) disable iff (!nrst)
        !hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");

    a_hrdata_stable: assert property (@(posedge clk) disable iff (!nrst)
        hreadyout |=> $stable(hrdata))
        else $error("read data changed outside a read");

    a_read_status: assert property (@(posedge clk) disable iff (!nrst)
        hit(reg_addr, `STATUS_OFS) && !hreadyout |=> hrdata == $past(status_r))
        else $error("status read returned wrong word");

    a_read_irq_stat: assert property (@(posedge clk) disable iff (!nrst)
        hit(reg_addr, `IRQ_STAT_OFS) && !hreadyout |=> hrdata == $past(irq_stat_r))
        else $error("irq status read returned wrong word");

    a_read_irq_en: assert property (@(posedge clk) disable iff (!nrst)
        hit(reg_addr, `IRQ_EN_OFS) && !hreadyout |=> hrdata == $past(irq_en_r))
        else $error("irq enable read returned wrong word");

    a_read_clear_zero: assert property (@(posedge clk) disable iff (!nrst)
        hit(reg_addr, `IRQ_CLR_OFS) && !hreadyout |=> hrdata == 32'h0000_0000)
        else $error("clear register read nonzero");

endmodule : reset_cause_flags

// file: sim/reset_cause_flags_test.sv
// self-checking bench of the reset-cause flag block
`timescale 1ns/100ps
`include "reset_cause_cfg.svh"

module reset_cause_flags_test;
    logic                      clk;
    logic                      nrst;
    logic                      hsel;
    logic                      hwrite;
    logic                      hreadyout;
    logic                      hresp;
    logic                      rd_ph;
    logic                      sleep_mode;
    logic                      idle_mode;
    logic                      regulator_enable;
    logic                      irq;
    logic [7:0]                haddr;
    logic [1:0]                htrans;
    logic [2:0]                hsize;
    logic [5:0]                ev;
    logic [31:0]               seed;
    reset_cause_pkg::word_type hwdata;
    reset_cause_pkg::word_type hrdata;
    reset_cause_pkg::word_type stat_m;
    reset_cause_pkg::word_type exp_q[$];
    int                        err_count;
    int                        cmp_count;
    int                        ev_bit[6] = '{0, 1, 4, 6, 7, 9};

    reset_cause_flags i_reset_cause_flags (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .config_mismatch_reset(ev[5]), .master_clear_pin_reset(ev[4]),
        .software_reset(ev[3]), .watchdog_timer_expired(ev[2]), .brownout_reset(ev[1]),
        .power_on_reset(ev[0]), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .regulator_enable(regulator_enable), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task automatic check_word(input reset_cause_pkg::word_type got, input reset_cause_pkg::word_type exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : check_word

    // compares irq (sel 0) or regulator_enable (sel 1) mid-cycle
    task automatic check_lvl(input int sel, input logic exp);
        @(negedge clk);
        cmp_count++;
        if ((sel == 0 ? irq : regulator_enable) !== exp) begin
            err_count++;
            $display("wrong value at %0t: level output %0d not %b", $time, sel, exp);
        end
        @(posedge clk);
    endtask : check_lvl

    task automatic wait_rdy();
        int n;
        n = 0;
        @(negedge clk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (hreadyout !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: bus wait timed out", $time);
            finish_test();
        end
        @(posedge clk);
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] a, input reset_cause_pkg::word_type d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !wr;
        wait_rdy();
        rd_ph <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input reset_cause_pkg::word_type e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
        @(posedge clk);
    endtask : pulse

    // event pulse lands in the write data phase
    task automatic bus_ev(input logic [7:0] a, input reset_cause_pkg::word_type d, input int i);
        fork
            bus(1'b1, a, d);
            begin
                @(posedge clk);
                pulse(i);
            end
        join
    endtask : bus_ev

    // read results are judged where they appear
    always @(negedge clk) begin
        if (rd_ph && hreadyout === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("wrong value at %0t: unexpected read data", $time);
            end else begin
                check_word(hrdata, exp_q.pop_front());
                check_word({31'h0000_0000, hresp}, 32'h0000_0000);
            end
        end
    end

    task automatic finish_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        {nrst, hsel, hwrite, rd_ph, sleep_mode, idle_mode} = 6'h00;
        {haddr, htrans, hsize, ev, hwdata} = '0;
        seed = 32'h0001_66AE;
        err_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check_lvl(1, 1'b1);
        check_lvl(0, 1'b0);
        rd(`STATUS_OFS, `STATUS_RESET);
        bus(1'b1, `STATUS_OFS, 32'h0);
        rd(`STATUS_OFS, 32'h0);
        stat_m = 32'h0;
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            stat_m[ev_bit[i]] = 1'b1;
            rd(`STATUS_OFS, stat_m);
        end
        sleep_mode <= 1'b1;
        repeat (2) @(posedge clk);
        check_lvl(1, 1'b0);
        bus(1'b1, `STATUS_OFS, stat_m | 32'h100);
        @(posedge clk);
        check_lvl(1, 1'b1);
        sleep_mode <= 1'b0;
        idle_mode <= 1'b1;
        @(posedge clk);
        idle_mode <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`STATUS_OFS, stat_m | 32'h10C);
        bus(1'b1, `IRQ_CLR_OFS, 32'h3FF);
        rd(`IRQ_STAT_OFS, 32'h0);
        bus(1'b1, `IRQ_EN_OFS, 32'h10);
        pulse(2);
        check_lvl(0, 1'b1);
        bus(1'b1, `IRQ_CLR_OFS, 32'h10);
        check_lvl(0, 1'b0);
        pulse(3);
        check_lvl(0, 1'b0);
        rd(`IRQ_STAT_OFS, 32'h40);
        rd(`IRQ_EN_OFS, 32'h10);
        bus_ev(`STATUS_OFS, 32'h0, 3);
        rd(`STATUS_OFS, 32'h40);
        bus_ev(`IRQ_CLR_OFS, 32'h40, 3);
        rd(`IRQ_STAT_OFS, 32'h40);
        for (int i = 0; i < 5; i++) begin
            stat_m = (i == 0) ? 32'hFFFF_FFFF : xorshift();
            bus(1'b1, `STATUS_OFS, stat_m);
            rd(`STATUS_OFS, stat_m & `WRITE_MASK);
        end
        bus(1'b1, 8'h10, xorshift());
        rd(8'h10, 32'h0);
        bus(1'b1, `STATUS_OFS, 32'h0);
        rd(`STATUS_OFS, 32'h0);
        finish_test();
    end
endmodule : reset_cause_flags_test
